//--- logic/ttx_regs.vh
`ifndef TTX_REGS_VH
`define TTX_REGS_VH

// ************************************************************
// Instruction codes, ten bits wide
// ************************************************************
`define TTX_OP_WIDTH          10
`define TTX_OP_LOAD_T3_LOW    10'h234
`define TTX_OP_READ_T1_PAIR   10'h270
`define TTX_OP_READ_T2_PAIR   10'h271
`define TTX_OP_COPY_B_TO_ACC  10'h01E

// ************************************************************
// Decoded operation vector, one bit per instruction
// ************************************************************
`define TTX_SEL_WIDTH         4
`define TTX_SEL_LOAD_T3       0
`define TTX_SEL_COPY_B        1
`define TTX_SEL_READ_T1       2
`define TTX_SEL_READ_T2       3

// ************************************************************
// Field positions and reset values
// ************************************************************
`define TTX_HI_MSB            7
`define TTX_HI_LSB            4
`define TTX_LO_MSB            3
`define TTX_LO_LSB            0
`define TTX_NIBBLE_RESET      4'h0
`define TTX_TIMER_RESET       8'h00

// ************************************************************
// Timing: every instruction here takes one machine cycle
// ************************************************************
`define TTX_EXEC_CYCLES       1
`define TTX_WORDS             1

`endif

//--- logic/ttx_decode.v
`timescale 1ns/10ps
`default_nettype none

`include "ttx_regs.vh"

module ttx_decode
(
    input  wire [`TTX_OP_WIDTH-1:0]  instr_word,
    input  wire                      instr_valid,
    output wire [`TTX_SEL_WIDTH-1:0] op_select,
    output wire                      op_known
);

    // ************************************************************
    // Decode table
    // ************************************************************
    // Full ten-bit compare: neighbouring codes belong to other
    // timer instructions, so no bit may be treated as don't-care.
    function [`TTX_SEL_WIDTH-1:0] ttx_match;
        input [`TTX_OP_WIDTH-1:0] code;
        begin
            ttx_match = {`TTX_SEL_WIDTH{1'b0}};
            ttx_match[`TTX_SEL_LOAD_T3] = (code == `TTX_OP_LOAD_T3_LOW);
            ttx_match[`TTX_SEL_COPY_B]  = (code == `TTX_OP_COPY_B_TO_ACC);
            ttx_match[`TTX_SEL_READ_T1] = (code == `TTX_OP_READ_T1_PAIR);
            ttx_match[`TTX_SEL_READ_T2] = (code == `TTX_OP_READ_T2_PAIR);
        end
    endfunction

    assign op_select = instr_valid ? ttx_match(instr_word) : {`TTX_SEL_WIDTH{1'b0}};
    assign op_known  = |op_select;

endmodule // ttx_decode

`default_nettype wire

//--- logic/ttx_top.v
// Functional notes
// - Code 234 loads timer 3 from low reload
// - Copy instruction sets accumulator to B, B kept
// - Code 270 puts timer 1 bits 7-4 in B
// - Code 270 puts timer 1 bits 3-0 in accumulator
// - Code 271 puts timer 2 bits 7-4 in B
// - Code 271 puts timer 2 bits 3-0 in accumulator
`timescale 1ns/10ps
`default_nettype none

`include "ttx_regs.vh"

module ttx_top
(
    input  wire                     clock,
    input  wire                     rst_n,
    input  wire                     clock_enable,
    input  wire                     instr_valid,
    input  wire [`TTX_OP_WIDTH-1:0] instr_word,
    input  wire [7:0]               timer1_value,
    input  wire [7:0]               timer2_value,
    input  wire [7:0]               timer3_low_reload_register,
    input  wire                     acc_write,
    input  wire [3:0]               acc_write_data,
    input  wire                     reg_b_write,
    input  wire [3:0]               reg_b_write_data,
    input  wire                     carry_write,
    input  wire                     carry_write_data,
    output reg  [3:0]               accumulator,
    output reg  [3:0]               reg_b,
    output reg                      carry_flag,
    output reg                      timer3_load,
    output reg  [7:0]               timer3_load_value,
    output reg                      instr_done,
    output reg                      instr_unknown,
    output reg                      skip_next
);

    // ************************************************************
    // Reset release
    // ************************************************************
    // Assertion is immediate; release is retimed through two stages
    // so no flop leaves reset on a different edge from its neighbours.
    reg rst_sync_a;
    reg rst_sync_b;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    wire rst_core_n;
    assign rst_core_n = rst_sync_b;

    // ************************************************************
    // Decode
    // ************************************************************
    wire [`TTX_SEL_WIDTH-1:0] op_select;
    wire                      op_known;

    ttx_decode u_decode
    (
        .instr_word  (instr_word),
        .instr_valid (instr_valid),
        .op_select   (op_select),
        .op_known    (op_known)
    );

    // The decoder compares full codes, so at most one select is high
    // and the update paths below never compete for a register.
    wire do_load_t3;
    wire do_copy_b;
    wire do_read_t1;
    wire do_read_t2;

    assign do_load_t3 = op_select[`TTX_SEL_LOAD_T3];
    assign do_copy_b  = op_select[`TTX_SEL_COPY_B];
    assign do_read_t1 = op_select[`TTX_SEL_READ_T1];
    assign do_read_t2 = op_select[`TTX_SEL_READ_T2];

    // ************************************************************
    // Next values of the accumulator and register B
    // ************************************************************
    // An instruction of this block outranks a plain write from the
    // rest of the CPU in the same cycle; the fetch path never issues
    // both, so the order only matters for a misbehaving neighbour.
    reg [3:0] next_accumulator;
    reg [3:0] next_reg_b;

    always @*
    begin
        next_accumulator = accumulator;
        next_reg_b       = reg_b;
        if (acc_write)
        begin
            next_accumulator = acc_write_data;
        end
        if (reg_b_write)
        begin
            next_reg_b = reg_b_write_data;
        end
        if (do_copy_b)
        begin
            next_accumulator = reg_b;
            next_reg_b       = reg_b;
        end
        if (do_read_t1)
        begin
            next_reg_b = timer1_value[`TTX_HI_MSB:`TTX_HI_LSB];
        end
        if (do_read_t1)
        begin
            next_accumulator = timer1_value[`TTX_LO_MSB:`TTX_LO_LSB];
        end
        if (do_read_t2)
        begin
            next_reg_b = timer2_value[`TTX_HI_MSB:`TTX_HI_LSB];
        end
        if (do_read_t2)
        begin
            next_accumulator = timer2_value[`TTX_LO_MSB:`TTX_LO_LSB];
        end
    end

    // ************************************************************
    // Working registers
    // ************************************************************
    always @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            accumulator <= `TTX_NIBBLE_RESET;
            reg_b       <= `TTX_NIBBLE_RESET;
        end
        else if (clock_enable)
        begin
            accumulator <= next_accumulator;
            reg_b       <= next_reg_b;
        end
    end

    // ************************************************************
    // Carry flag
    // ************************************************************
    // None of the four instructions moves the carry; only the
    // general write port does, so a flag set earlier survives them.
    // carry untouched here
    always @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            carry_flag <= 1'b0;
        end
        else if (clock_enable && carry_write)
        begin
            carry_flag <= carry_write_data;
        end
    end

    // ************************************************************
    // Timer 3 load strobe
    // ************************************************************
    // The value is sampled with the strobe so the timer sees a stable
    // copy even if the reload register changes in the next cycle.
    always @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            timer3_load       <= 1'b0;
            timer3_load_value <= `TTX_TIMER_RESET;
        end
        else if (clock_enable)
        begin
            timer3_load <= do_load_t3;
            if (do_load_t3)
            begin
                timer3_load_value <= timer3_low_reload_register;
            end
        end
    end

    // ************************************************************
    // Completion, unknown code and skip
    // ************************************************************
    always @(posedge clock or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            instr_done    <= 1'b0;
            instr_unknown <= 1'b0;
            skip_next     <= 1'b0;
        end
        else if (clock_enable)
        begin
            instr_done    <= op_known;
            instr_unknown <= instr_valid & ~op_known;
            // Kept as a flop so the fetch path sees a registered
            // signal, like every other output of this block.
            // never skips
            skip_next     <= 1'b0;
        end
    end

endmodule // ttx_top

`default_nettype wire

//--- test/ttx_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "ttx_regs.vh"
module ttx_top_monitor
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       clock_enable,
    input wire logic       instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [7:0] timer1_value,
    input wire logic [7:0] timer2_value,
    input wire logic [7:0] timer3_low_reload_register,
    input wire logic       carry_write,
    input wire logic [3:0] accumulator,
    input wire logic [3:0] reg_b,
    input wire logic       carry_flag,
    input wire logic       timer3_load,
    input wire logic [7:0] timer3_load_value,
    input wire logic       instr_done,
    input wire logic       skip_next
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take;
    assign take = clock_enable && instr_valid;
    a_load_timer3: assert property (take && instr_word == `TTX_OP_LOAD_T3_LOW |=>
        timer3_load && timer3_load_value == $past(timer3_low_reload_register)) else $error("load");
    a_copy_b_acc: assert property (take && instr_word == `TTX_OP_COPY_B_TO_ACC |=>
        accumulator == $past(reg_b) && $stable(reg_b)) else $error("copy");
    a_t1_high: assert property (take && instr_word == `TTX_OP_READ_T1_PAIR |=>
        reg_b == $past(timer1_value[7:4])) else $error("t1 high");
    a_t1_low: assert property (take && instr_word == `TTX_OP_READ_T1_PAIR |=>
        accumulator == $past(timer1_value[3:0])) else $error("t1 low");
    a_t2_high: assert property (take && instr_word == `TTX_OP_READ_T2_PAIR |=>
        reg_b == $past(timer2_value[7:4])) else $error("t2 high");
    a_t2_low: assert property (take && instr_word == `TTX_OP_READ_T2_PAIR |=>
        accumulator == $past(timer2_value[3:0])) else $error("t2 low");
    a_done_one_cycle: assert property (take && (instr_word == `TTX_OP_LOAD_T3_LOW ||
        instr_word == `TTX_OP_COPY_B_TO_ACC || instr_word == `TTX_OP_READ_T1_PAIR ||
        instr_word == `TTX_OP_READ_T2_PAIR) |=> instr_done) else $error("done");
    a_carry_kept: assert property (clock_enable && !carry_write |=> $stable(carry_flag))
        else $error("carry");
    a_never_skip: assert property (skip_next == 1'b0) else $error("skip");
endmodule // ttx_top_monitor
bind ttx_top ttx_top_monitor i_ttx_top_monitor (.clock(clock), .rst_n(rst_n),
    .clock_enable(clock_enable), .instr_valid(instr_valid), .instr_word(instr_word),
    .timer1_value(timer1_value), .timer2_value(timer2_value),
    .timer3_low_reload_register(timer3_low_reload_register), .carry_write(carry_write),
    .accumulator(accumulator), .reg_b(reg_b), .carry_flag(carry_flag),
    .timer3_load(timer3_load), .timer3_load_value(timer3_load_value),
    .instr_done(instr_done), .skip_next(skip_next));
`default_nettype wire

//--- test/ttx_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ttx_regs.vh"
module ttx_top_tb;
    logic clock = 0, rst_n = 0, ce = 0, v = 0, aw = 0, bw = 0, cw = 0, cd = 0;
    logic [9:0] w = 0;
    logic [7:0] t1 = 0, t2 = 0, r3 = 0;
    logic [3:0] ad = 0, bd = 0;
    wire [20:0] got;
    logic [20:0] exp;
    int fail_count = 0, comparisons = 0;
    ttx_top i_ttx_top (.clock(clock), .rst_n(rst_n), .clock_enable(ce), .instr_valid(v),
        .instr_word(w), .timer1_value(t1), .timer2_value(t2),
        .timer3_low_reload_register(r3), .acc_write(aw), .acc_write_data(ad),
        .reg_b_write(bw), .reg_b_write_data(bd), .carry_write(cw), .carry_write_data(cd),
        .accumulator(got[20:17]), .reg_b(got[16:13]), .carry_flag(got[12]),
        .timer3_load(got[11]), .timer3_load_value(got[10:3]), .instr_done(got[2]),
        .instr_unknown(got[1]), .skip_next(got[0]));
    always #50 clock = ~clock;
    // Disabled cycles hold every output, pulses included
    function automatic logic [20:0] nxt(input logic [20:0] s);
        logic [3:0] a, b;
        logic c, l, d, u;
        logic [7:0] t;
        if (!ce)
            return s;
        {a, b, c, l, t, d, u} = s[20:1];
        {l, d, u} = 3'h0;
        if (cw)
            c = cd;
        if (v)
            case (w)
                `TTX_OP_LOAD_T3_LOW: {l, t, d} = {1'b1, r3, 1'b1};
                `TTX_OP_COPY_B_TO_ACC: {a, d} = {b, 1'b1};
                `TTX_OP_READ_T1_PAIR: {b, a, d} = {t1, 1'b1};
                `TTX_OP_READ_T2_PAIR: {b, a, d} = {t2, 1'b1};
                default: u = 1'b1;
            endcase
        else
        begin
            if (aw)
                a = ad;
            if (bw)
                b = bd;
        end
        return {a, b, c, l, t, d, u, 1'b0};
    endfunction
    task automatic check_out();
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Writes only ride on idle cycles, where no instruction competes
    task automatic apply(logic e, logic vv, logic [9:0] ww, logic [7:0] a1, logic [7:0] a2);
        {ce, v, w, t1, t2, r3} = {e, vv, ww, a1, a2, a1 ^ a2};
        {aw, bw, cw} = vv ? 3'h0 : 3'($urandom);
        {ad, bd, cd} = 9'($urandom);
        exp = nxt(exp);
        @(negedge clock);
        check_out();
    endtask
    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        // Four times the cycles of reset, hand cases and random loop
        #((4 + 3 + 6 + 400) * 100 * 4);
        fail_count++;
        complete_run();
    end
    initial
    begin
        logic [9:0] ops[5];
        int k;
        ops = '{`TTX_OP_LOAD_T3_LOW, `TTX_OP_COPY_B_TO_ACC, `TTX_OP_READ_T1_PAIR,
            `TTX_OP_READ_T2_PAIR, 10'h3FF};
        exp = 0;
        void'($urandom(32'h4229EA4B));
        repeat (4) @(negedge clock);
        rst_n = 1;
        repeat (3) @(negedge clock);
        check_out();
        // Back to back with boundary values, then a refused unknown code
        apply(1, 1, `TTX_OP_READ_T1_PAIR, 8'hA5, 8'h00);
        apply(1, 1, `TTX_OP_COPY_B_TO_ACC, 8'h00, 8'h00);
        apply(1, 1, `TTX_OP_LOAD_T3_LOW, 8'hFF, 8'h00);
        apply(0, 1, `TTX_OP_READ_T2_PAIR, 8'h00, 8'hFF);
        apply(1, 1, `TTX_OP_READ_T2_PAIR, 8'h00, 8'hFF);
        apply(1, 1, 10'h3FF, 8'h12, 8'h34);
        repeat (400)
        begin
            k = $urandom % 6;
            apply(($urandom % 5) != 0, k != 5, (k < 4) ? ops[k] : 10'($urandom),
                8'($urandom), 8'($urandom));
        end
        complete_run();
    end
endmodule // ttx_top_tb
`default_nettype wire
